// [core/vsm_pkg.sv]
// constants, field layouts and carrier types of the video stream debug monitor
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package vsm_pkg;
   localparam int         CW         = 8;         // bits per colour component
   localparam int         DW         = 3 * CW;    // red, blue, green from msb
   localparam int         LW         = 13;        // pixel and line count width
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_ERR    = 8'h08;
   localparam logic [7:0] OFF_FRM    = 8'h14;
   localparam logic [7:0] OFF_LIN    = 8'h18;
   localparam logic [7:0] OFF_PIX    = 8'h1C;
   localparam logic [7:0] OFF_SIZE   = 8'h20;
   localparam int         CTRL_BYP   = 4;
   localparam int         CTRL_PAT   = 5;
   localparam int         CTRL_SRST  = 30;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] SRST_KEEP = 32'h4000_0000; // only reset bit survives
   localparam int         ERR_LS     = 0;
   localparam int         ERR_LL     = 1;
   localparam int         ERR_FS     = 2;
   localparam int         ERR_FL     = 3;
   localparam int         SZ_H_LSB   = 16;        // height field of size register
   localparam logic [LW-1:0] WID_RST = 13'h0780;
   localparam logic [LW-1:0] HGT_RST = 13'h0438;
   localparam logic [LW-1:0] BAR_LINES = 13'h0100;
   localparam int         BAR_SH     = 6;         // 64 pixels per bar
   localparam logic [1:0] SKIP_LINES = 2'h2;
   localparam logic [4:0] INIT_LAST  = 5'h0F;     // 16 cycles of initialisation
   localparam longint unsigned CLK_HZ   = 64'd25_000_000;
   localparam longint unsigned EVAL_HRS = 64'd8;
   localparam longint unsigned EVAL_CYC = EVAL_HRS * 64'd3600 * CLK_HZ;
   localparam logic [1:0] RESP_OK    = 2'h0;
   localparam logic [1:0] RESP_SLV   = 2'h2;
   typedef struct packed {
      logic [DW-1:0] data;
      logic          last;
      logic          sof;
   } vsm_beat_t;
   typedef enum logic [1:0] {ST_INIT = 2'b01, ST_RUN = 2'b10} vsm_st_t;
endpackage

// [core/vsm_top.sv]
// stream buffer and top level of the video stream debug monitor
`timescale 1ns/1ps

//------------------------------------------------------------------------------
// stream fifo
//------------------------------------------------------------------------------
module vsm_fifo #(
   parameter int W  = 8,
   parameter int D  = 16,
   parameter int AW = $clog2(D)
) (
   input  logic          clk,
   input  logic          rst,
   input  logic [W-1:0]  wdata,
   input  logic          wvalid,
   output logic          wready,
   output logic [W-1:0]  rdata,
   output logic          rvalid,
   input  logic          rready,
   output logic [AW:0]   level
);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic          wr;
   logic          rd;

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == AW'(D - 1)) ? '0 : p + 1'b1;
   endfunction

   // handshakes and flags
   assign wready = (cnt_q != (AW + 1)'(D));
   assign rvalid = (cnt_q != '0);
   assign wr     = wvalid & wready;
   assign rd     = rready & rvalid;
   assign rdata  = mem[rp_q];
   assign level  = cnt_q;

   // storage
   always_ff @(posedge clk) begin
      if (wr) begin
         mem[wp_q] <= wdata;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (wr) begin
            wp_q <= nxt(wp_q);
         end
         if (rd) begin
            rp_q <= nxt(rp_q);
         end
         cnt_q <= cnt_q + (AW + 1)'(wr) - (AW + 1)'(rd);
      end
   end
endmodule

//------------------------------------------------------------------------------
// top level
//------------------------------------------------------------------------------
module vsm_top
   import vsm_pkg::*;
#(
   parameter bit              DEBUG_EN = 1'b1,
   parameter bit              EVAL     = 1'b0,
   parameter longint unsigned TMO_CYC  = EVAL_CYC,
   parameter int              DEPTH    = 16
) (
   input  logic           mclk,
   input  logic           stream_reset_n,
   input  logic           ctrl_reset_n,
   input  logic           aclken,
   input  logic [DW-1:0]  s_axis_video_tdata,
   input  logic           s_axis_video_tvalid,
   output logic           s_axis_video_tready,
   input  logic           s_axis_video_tlast,
   input  logic           s_axis_video_tuser,
   output logic [DW-1:0]  m_axis_video_tdata,
   output logic           m_axis_video_tvalid,
   input  logic           m_axis_video_tready,
   output logic           m_axis_video_tlast,
   output logic           m_axis_video_tuser,
   input  logic [7:0]     s_axi_awaddr,
   input  logic           s_axi_awvalid,
   output logic           s_axi_awready,
   input  logic [31:0]    s_axi_wdata,
   input  logic [3:0]     s_axi_wstrb,
   input  logic           s_axi_wvalid,
   output logic           s_axi_wready,
   output logic [1:0]     s_axi_bresp,
   output logic           s_axi_bvalid,
   input  logic           s_axi_bready,
   input  logic [7:0]     s_axi_araddr,
   input  logic           s_axi_arvalid,
   output logic           s_axi_arready,
   output logic [31:0]    s_axi_rdata,
   output logic [1:0]     s_axi_rresp,
   output logic           s_axi_rvalid,
   input  logic           s_axi_rready
);
   localparam int FAW = $clog2(DEPTH);

   logic            rst;
   logic            crst;
   logic            srst;
   logic            byp;
   logic            pat;
   logic [31:0]     ctrl_q;
   logic [31:0]     ctrl_d;
   logic [31:0]     size_w;
   logic [LW-1:0]   wid_q;
   logic [LW-1:0]   hgt_q;
   logic [3:0]      err_q;
   logic [3:0]      err_set;
   logic [3:0]      err_clr;
   logic [31:0]     frm_q;
   logic [31:0]     lin_q;
   logic [31:0]     pix_q;
   logic            awr_q;
   logic            bv_q;
   logic [1:0]      br_q;
   logic            arr_q;
   logic            rv_q;
   logic [1:0]      rr_q;
   logic [31:0]     rd_q;
   logic [31:0]     rd_mux;
   logic            wr_hs;
   vsm_st_t         st_q;
   logic [4:0]      ini_q;
   logic            srdy_q;
   logic            acc;
   logic            drop;
   logic            push_in;
   logic [LW-1:0]   xin_q;
   logic [LW-1:0]   yin_q;
   logic            sofs_q;
   logic [1:0]      ln_q;
   vsm_beat_t       ibeat;
   logic [LW-1:0]   gx_q;
   logic [LW-1:0]   gy_q;
   logic            gen_go;
   logic [CW-1:0]   lum;
   vsm_beat_t       gbeat;
   vsm_beat_t       f_wd;
   vsm_beat_t       f_rd;
   logic            f_wv;
   logic            f_wr;
   logic            f_rv;
   logic            f_rr;
   logic [FAW:0]    f_lvl;
   logic            mv_q;
   vsm_beat_t       mb_q;
   logic            out_hs;
   logic [39:0]     tmo_c_q;
   logic            tmo_q;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
      end
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = a inside {OFF_CTRL, OFF_ERR, OFF_FRM, OFF_LIN, OFF_PIX, OFF_SIZE};
   endfunction

   function automatic logic [DW-1:0] bar(input logic [2:0] i);
      bar = {{CW{i[2]}}, {CW{i[1]}}, {CW{i[0]}}}; // red, blue, green
   endfunction

   // resets and mode selects
   assign rst  = ~stream_reset_n | ~ctrl_reset_n;
   assign srst = ctrl_q[CTRL_SRST];
   assign crst = rst | srst;
   assign byp  = DEBUG_EN & ctrl_q[CTRL_BYP];
   assign pat  = DEBUG_EN & ctrl_q[CTRL_PAT];

   //---------------------------------------------------------------------------
   // control port
   //---------------------------------------------------------------------------
   // write channel: one beat taken when address and data both wait
   assign wr_hs = awr_q & s_axi_awvalid & s_axi_wvalid;
   always_ff @(posedge mclk) begin
      if (rst) begin
         awr_q <= 1'b0;
         bv_q  <= 1'b0;
         br_q  <= RESP_OK;
      end else begin
         awr_q <= ~awr_q & ~bv_q & s_axi_awvalid & s_axi_wvalid;
         if (wr_hs) begin
            bv_q <= 1'b1;
            br_q <= mapped(s_axi_awaddr) ? RESP_OK : RESP_SLV;
         end else if (s_axi_bready) begin
            bv_q <= 1'b0;
         end
      end
   end

   // control register; reset bit wipes the others while held
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_hs && s_axi_awaddr == OFF_CTRL) begin
         ctrl_d = merge(ctrl_q, s_axi_wdata, s_axi_wstrb);
      end
      if (ctrl_d[CTRL_SRST]) begin
         ctrl_d = ctrl_d & SRST_KEEP;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // active size register
   assign size_w = merge({3'h0, hgt_q, 3'h0, wid_q}, s_axi_wdata, s_axi_wstrb);
   always_ff @(posedge mclk) begin
      if (crst) begin
         wid_q <= WID_RST;
         hgt_q <= HGT_RST;
      end else if (wr_hs && s_axi_awaddr == OFF_SIZE) begin
         wid_q <= size_w[LW-1:0];
         hgt_q <= size_w[SZ_H_LSB +: LW];
      end
   end

   // read mux
   always_comb begin
      case (s_axi_araddr)
         OFF_CTRL: rd_mux = ctrl_q;
         OFF_ERR:  rd_mux = {28'h0, err_q};
         OFF_FRM:  rd_mux = frm_q;
         OFF_LIN:  rd_mux = lin_q;
         OFF_PIX:  rd_mux = pix_q;
         OFF_SIZE: rd_mux = {3'h0, hgt_q, 3'h0, wid_q};
         default:  rd_mux = 32'h0;
      endcase
   end

   // read channel
   always_ff @(posedge mclk) begin
      if (rst) begin
         arr_q <= 1'b0;
         rv_q  <= 1'b0;
         rr_q  <= RESP_OK;
         rd_q  <= 32'h0;
      end else begin
         arr_q <= ~arr_q & ~rv_q & s_axi_arvalid;
         if (arr_q & s_axi_arvalid) begin
            rv_q <= 1'b1;
            rd_q <= rd_mux;
            rr_q <= mapped(s_axi_araddr) ? RESP_OK : RESP_SLV;
         end else if (s_axi_rready) begin
            rv_q <= 1'b0;
         end
      end
   end

   //---------------------------------------------------------------------------
   // input side
   //---------------------------------------------------------------------------
   // initialisation sequence after any reset
   always_ff @(posedge mclk) begin
      if (crst) begin
         st_q  <= ST_INIT;
         ini_q <= 5'h00;
      end else begin
         unique case (st_q)
            ST_INIT: begin
               ini_q <= ini_q + 5'h01;
               if (ini_q == INIT_LAST) begin
                  st_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               ini_q <= ini_q;
            end
         endcase
      end
   end

   // ready lags the fill level by one cycle, so two free places are kept
   always_ff @(posedge mclk) begin
      if (crst) begin
         srdy_q <= 1'b0;
      end else begin
         srdy_q <= (st_q == ST_RUN) & (pat | (f_lvl <= (FAW + 1)'(DEPTH - 2)));
      end
   end

   assign acc     = s_axis_video_tvalid & srdy_q & aclken;
   assign drop    = xin_q >= wid_q;
   assign push_in = acc & ~pat & (byp | (~drop & (ln_q == SKIP_LINES)));

   // input beat; processed path closes the line at the programmed width
   always_comb begin
      ibeat.data = s_axis_video_tdata;
      ibeat.last = s_axis_video_tlast | (~byp & (xin_q == wid_q - 13'h1));
      ibeat.sof  = s_axis_video_tuser;
   end

   // position within line and frame, lines seen since reset
   always_ff @(posedge mclk) begin
      if (crst) begin
         xin_q  <= '0;
         yin_q  <= '0;
         sofs_q <= 1'b0;
         ln_q   <= 2'h0;
      end else if (acc) begin
         if (s_axis_video_tlast) begin
            xin_q <= '0;
         end else if (xin_q != '1) begin
            xin_q <= xin_q + 13'h1;
         end
         if (s_axis_video_tuser) begin
            yin_q  <= {12'h0, s_axis_video_tlast};
            sofs_q <= 1'b1;
         end else if (s_axis_video_tlast && yin_q != '1) begin
            yin_q <= yin_q + 13'h1;
         end
         if (s_axis_video_tlast && ln_q != SKIP_LINES) begin
            ln_q <= ln_q + 2'h1;
         end
      end
   end

   // framing checks
   always_comb begin
      err_set = 4'h0;
      if (acc) begin
         err_set[ERR_LS] = s_axis_video_tlast & ({1'b0, xin_q} + 14'h1 < {1'b0, wid_q});
         err_set[ERR_LL] = drop;
         err_set[ERR_FS] = s_axis_video_tuser & sofs_q & (yin_q < hgt_q);
         err_set[ERR_FL] = s_axis_video_tuser & sofs_q & (yin_q > hgt_q);
      end
   end

   // sticky flags, write one to clear, a new event wins over the clear
   assign err_clr = (wr_hs && s_axi_awaddr == OFF_ERR) ? s_axi_wdata[3:0] : 4'h0;
   always_ff @(posedge mclk) begin
      if (crst) begin
         err_q <= 4'h0;
      end else begin
         err_q <= (err_q & ~err_clr) | err_set;
      end
   end

   //---------------------------------------------------------------------------
   // test pattern
   //---------------------------------------------------------------------------
   assign gen_go = pat & aclken & f_wr & (st_q == ST_RUN);
   assign lum    = gx_q[CW-1:0] + gy_q[CW-1:0];

   always_comb begin
      gbeat.sof  = (gx_q == '0) && (gy_q == '0);
      gbeat.last = (gx_q == wid_q - 13'h1);
      gbeat.data = (gy_q < BAR_LINES) ? bar(gx_q[BAR_SH +: 3]) : {3{lum}};
   end

   // raster counters restart whenever the pattern is switched on
   always_ff @(posedge mclk) begin
      if (crst | ~pat) begin
         gx_q <= '0;
         gy_q <= '0;
      end else if (gen_go) begin
         if (gbeat.last) begin
            gx_q <= '0;
            gy_q <= (gy_q >= hgt_q - 13'h1) ? '0 : gy_q + 13'h1;
         end else begin
            gx_q <= gx_q + 13'h1;
         end
      end
   end

   //---------------------------------------------------------------------------
   // buffer and output stage
   //---------------------------------------------------------------------------
   assign f_wv = pat ? gen_go : push_in;
   assign f_wd = pat ? gbeat : ibeat;

   vsm_fifo #(
      .W ($bits(vsm_beat_t)),
      .D (DEPTH)
   ) u_fifo (
      .clk    (mclk),
      .rst    (crst),
      .wdata  (f_wd),
      .wvalid (f_wv),
      .wready (f_wr),
      .rdata  (f_rd),
      .rvalid (f_rv),
      .rready (f_rr),
      .level  (f_lvl)
   );

   assign f_rr   = aclken & (~mv_q | m_axis_video_tready);
   assign out_hs = mv_q & m_axis_video_tready & aclken;

   // output register
   always_ff @(posedge mclk) begin
      if (crst) begin
         mv_q <= 1'b0;
         mb_q <= '0;
      end else if (f_rr) begin
         mv_q <= f_rv;
         if (f_rv) begin
            mb_q      <= f_rd;
            mb_q.data <= tmo_q ? '0 : f_rd.data;
         end
      end
   end

   // throughput counters
   always_ff @(posedge mclk) begin
      if (crst) begin
         frm_q <= 32'h0;
         lin_q <= 32'h0;
         pix_q <= 32'h0;
      end else if (out_hs) begin
         pix_q <= pix_q + 32'h1;
         if (mb_q.last) begin
            lin_q <= lin_q + 32'h1;
         end
         if (mb_q.sof) begin
            frm_q <= frm_q + 32'h1;
         end
      end
   end

   // evaluation timeout
   always_ff @(posedge mclk) begin
      if (rst) begin
         tmo_c_q <= 40'h0;
         tmo_q   <= 1'b0;
      end else if (EVAL && !tmo_q) begin
         tmo_c_q <= tmo_c_q + 40'h1;
         if (tmo_c_q == 40'(TMO_CYC - 64'd1)) begin
            tmo_q <= 1'b1;
         end
      end
   end

   // port drive
   assign s_axis_video_tready = srdy_q;
   assign m_axis_video_tvalid = mv_q;
   assign m_axis_video_tdata  = mb_q.data;
   assign m_axis_video_tlast  = mb_q.last;
   assign m_axis_video_tuser  = mb_q.sof;
   assign s_axi_awready       = awr_q;
   assign s_axi_wready        = awr_q;
   assign s_axi_bvalid        = bv_q;
   assign s_axi_bresp         = br_q;
   assign s_axi_arready       = arr_q;
   assign s_axi_rvalid        = rv_q;
   assign s_axi_rresp         = rr_q;
   assign s_axi_rdata         = rd_q;

   //---------------------------------------------------------------------------
   // checks
   //---------------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   AST_SRST_IDLE: assert property (srst |=> !srdy_q && !mv_q) else $error("soft reset left stream active");
   AST_INIT_LOW: assert property ($fell(crst) |-> !srdy_q [*8]) else $error("ready rose during init");
   AST_NO_OVF: assert property (push_in |-> f_wr) else $error("buffer overflow on input");
   AST_SKIP: assert property (ln_q != SKIP_LINES && !byp && !pat |-> !f_wv) else $error("early line output");
   AST_LL: assert property (acc && xin_q >= wid_q |=> err_q[ERR_LL]) else $error("line long missed");
   AST_LS: assert property (acc && s_axis_video_tlast && xin_q == 13'h0 && wid_q > 13'h1 |=> err_q[ERR_LS])
      else $error("line short missed");
   AST_STICKY: assert property (err_q[ERR_LS] && !err_clr[ERR_LS] && !srst |=> err_q[ERR_LS])
      else $error("flag lost");
   AST_PIX: assert property (out_hs && !srst |=> pix_q == $past(pix_q) + 32'h1) else $error("pixel count");
   AST_LIN: assert property (out_hs && mb_q.last && !srst |=> lin_q == $past(lin_q) + 32'h1)
      else $error("line count");
   AST_FRM: assert property (!out_hs && !srst |=> frm_q == $past(frm_q)) else $error("frame count moved");
   AST_BYP: assert property (byp && !pat && acc |-> f_wv && f_wd.data == s_axis_video_tdata)
      else $error("bypass lost sample");
   AST_BLACK: assert property (gen_go && gy_q < BAR_LINES && gx_q[BAR_SH +: 3] == 3'h0 |-> f_wd.data == '0)
      else $error("first bar not black");
   AST_TMO: assert property (tmo_q && f_rr && f_rv && !srst |=> mb_q.data == '0) else $error("timeout data");
endmodule

// [sim/test_vsm_top.sv]
// self-checking bench for the video stream debug monitor
`timescale 1ns/1ps
module test_vsm_top
   import vsm_pkg::*;
;
   logic          mclk = 1'h0, stream_reset_n = 1'h0, ctrl_reset_n = 1'h0;
   logic          aclken = 1'h1;
   logic [DW-1:0] s_axis_video_tdata = '0, m_axis_video_tdata;
   logic          s_axis_video_tvalid = 1'h0, s_axis_video_tlast = 1'h0, s_axis_video_tuser = 1'h0;
   logic          s_axis_video_tready, m_axis_video_tvalid, m_axis_video_tready, m_axis_video_tlast;
   logic          m_axis_video_tuser, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
   logic          s_axi_bready = 1'h1, s_axi_rready = 1'h1, stall = 1'h0, slow = 1'h0;
   logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]    s_axi_wstrb = 4'hF;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   int            failures = 0, total_checks = 0, acc, b0, n, cyc = 0;
   localparam int TMO = 8000; // evaluation timeout, short enough to reach within one run

   vsm_top #(.DEBUG_EN(1'b1), .EVAL(1'b1), .TMO_CYC(64'(TMO)), .DEPTH(16)) u_dut (.*);
   vsm_sink u_sink (.clk(mclk), .tdata(m_axis_video_tdata), .tvalid(m_axis_video_tvalid),
      .tlast(m_axis_video_tlast), .tuser(m_axis_video_tuser), .stall(stall), .slow(slow),
      .tready(m_axis_video_tready));

   // free running clock
   initial begin
      forever #20 mclk = ~mclk;
   end

   // cycles since the hardware reset was released, mirrors the timeout counter
   always @(posedge mclk) begin
      if (stream_reset_n && ctrl_reset_n) begin
         cyc <= cyc + 1;
      end
   end

   // bus, stream and compare helpers, all driven at the falling edge
   task automatic complete_run();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wt(ref logic s);
      int n;
      n = 0;
      while (s !== 1'b1) begin
         @(negedge mclk);
         n++;
         if (n > 400) begin
            failures++;
            $display("CHECK FAILED %0t wait timed out", $time);
            complete_run();
         end
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OK);
      s_axi_awaddr  = a;
      s_axi_wdata   = d;
      s_axi_awvalid = 1'h1;
      s_axi_wvalid  = 1'h1;
      wt(s_axi_awready);
      chk(s_axi_wready, 1);
      @(negedge mclk);
      s_axi_awvalid = 1'h0;
      s_axi_wvalid  = 1'h0;
      wt(s_axi_bvalid);
      chk({30'h0, s_axi_bresp}, {30'h0, r});
      @(negedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OK);
      s_axi_araddr  = a;
      s_axi_arvalid = 1'h1;
      wt(s_axi_arready);
      @(negedge mclk);
      s_axi_arvalid = 1'h0;
      wt(s_axi_rvalid);
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
      @(negedge mclk);
   endtask
   task automatic line(input int n, input logic [DW-1:0] b, input logic sof);
      for (int i = 0; i < n; i++) begin
         s_axis_video_tdata  = b + DW'(i);
         s_axis_video_tuser  = sof && i == 0;
         s_axis_video_tlast  = i == n - 1;
         s_axis_video_tvalid = 1'h1;
         wt(s_axis_video_tready);
         @(negedge mclk);
      end
      s_axis_video_tvalid = 1'h0;
   endtask

   // main sequence
   initial begin
      repeat (8) @(negedge mclk);
      stream_reset_n = 1'h1;
      ctrl_reset_n   = 1'h1;
      repeat (16) @(negedge mclk);
      chk(s_axis_video_tready, 0);
      @(negedge mclk);
      chk(s_axis_video_tready, 1);
      rd(OFF_CTRL, CTRL_RST);
      rd(OFF_PIX, 0);
      rd(8'h40, 0, RESP_SLV);
      wr(8'h40, 32'h1, RESP_SLV);
      wr(OFF_PIX, 32'h5);
      rd(OFF_PIX, 0);
      wr(OFF_SIZE, 32'h0002_0004);
      line(4, 0, 1);
      line(4, 0, 0);
      repeat (8) @(negedge mclk);
      chk(u_sink.beats, 0);
      wr(OFF_CTRL, 32'h10);
      slow = 1'h1;
      line(4, 24'hA05C30, 1);
      repeat (12) @(negedge mclk);
      for (int i = 0; i < 4; i++) chk(u_sink.mem[i], {i == 0, i == 3, 24'hA05C30 + 24'(i)});
      rd(OFF_FRM, 1);
      rd(OFF_LIN, 1);
      rd(OFF_PIX, 4);
      slow = 1'h0;
      line(6, 0, 0);
      line(2, 0, 0);
      rd(OFF_ERR, 3);
      rd(OFF_ERR, 3);
      wr(OFF_ERR, 3);
      rd(OFF_ERR, 0);
      line(4, 0, 1);
      line(4, 0, 1);
      rd(OFF_ERR, 32'hC);
      wr(OFF_CTRL, 0);
      b0 = u_sink.beats;
      line(6, 0, 0);
      repeat (8) @(negedge mclk);
      chk(u_sink.beats - b0, 4);
      wr(OFF_CTRL, 32'h10);
      stall = 1'h1;
      b0 = u_sink.beats;
      acc = 0;
      s_axis_video_tlast  = 1'h0;
      s_axis_video_tvalid = 1'h1;
      repeat (40) begin
         if (s_axis_video_tready) acc++;
         @(negedge mclk);
      end
      s_axis_video_tvalid = 1'h0;
      chk(s_axis_video_tready, 0);
      chk(acc > 12 && acc < 20, 1);
      stall = 1'h0;
      repeat (40) @(negedge mclk);
      chk(u_sink.beats - b0, acc);
      // clock enable low: a waiting beat is not taken until the enable returns
      b0                  = u_sink.beats;
      aclken              = 1'h0;
      s_axis_video_tvalid = 1'h1;
      repeat (8) @(negedge mclk);
      aclken = 1'h1;
      @(negedge mclk);
      s_axis_video_tvalid = 1'h0;
      repeat (8) @(negedge mclk);
      chk(u_sink.beats - b0, 1);
      wr(OFF_CTRL, 32'h4000_0010);
      chk(s_axis_video_tready, 0);
      chk(m_axis_video_tvalid, 0);
      rd(OFF_CTRL, SRST_KEEP);
      rd(OFF_PIX, 0);
      wr(OFF_CTRL, 0);
      wr(OFF_SIZE, 32'h0002_0082);
      wr(OFF_CTRL, 32'h20);
      for (int k = 0; k < 4; k++) line(130, 0, k[0] == 1'b0);
      repeat (200) @(negedge mclk);
      chk(u_sink.mem[0][DW-1:0], 0);
      chk(u_sink.mem[64][DW-1:0], 24'h0000FF);
      chk(u_sink.mem[128][DW-1:0], 24'h00FF00);
      // tall frame: lines 256 and 257 carry the ramp, gray is x plus y low byte
      wr(OFF_CTRL, 0);
      wr(OFF_SIZE, 32'h0102_0004);
      wr(OFF_CTRL, 32'h20);
      n = -1;
      for (int c = 0; c < 1400 && n < 1031; c++) begin
         if (m_axis_video_tvalid && m_axis_video_tready) begin
            n = m_axis_video_tuser ? 0 : (n < 0 ? n : n + 1);
            if (n == 1026) chk(m_axis_video_tdata, 24'h020202);
            if (n == 1030) chk(m_axis_video_tdata, 24'h030303);
         end
         @(negedge mclk);
      end
      chk(n, 1031);
      // evaluation timeout: once it has run out, forwarded data reads as zero
      wr(OFF_CTRL, 32'h10);
      for (int c = 0; c < 9000 && cyc <= TMO; c++) @(negedge mclk);
      chk(cyc > TMO, 1);
      line(2, 24'hA05C30, 1);
      repeat (8) @(negedge mclk);
      chk(u_sink.mem[0], {1'b1, 1'b0, 24'h0});
      complete_run();
   end
endmodule

// [sim/vsm_sink.sv]
// downstream video sink model with stall and slow pacing
`timescale 1ns/1ps
module vsm_sink
   import vsm_pkg::*;
(
   input  wire logic          clk,
   input  wire logic [DW-1:0] tdata,
   input  wire logic          tvalid,
   input  wire logic          tlast,
   input  wire logic          tuser,
   input  wire logic          stall,
   input  wire logic          slow,
   output logic               tready
);
   logic [DW+1:0] mem [512];
   logic [8:0]    x     = 9'h000;
   logic          tog   = 1'h0;
   int            beats = 0;
   // ready changes just after an edge; slow pacing drops it every other cycle
   always_ff @(posedge clk) begin
      tog    <= ~tog;
      tready <= !stall && !(slow && tog);
   end
   // taken beats stored by pixel index, a frame start restarts the index
   always_ff @(posedge clk) begin
      if (tvalid && tready) begin
         mem[tuser ? 9'h000 : x] <= {tuser, tlast, tdata};
         x     <= tuser ? 9'h001 : x + 9'h001;
         beats <= beats + 1;
      end
   end
endmodule
